// file: src/rip_pkg.sv
/*
  Package for the radio interrupt and data port block: register addresses,
  flag bit positions, reset values and data-port constants.
  Assumes a byte-wide special-function register port from the CPU core.
*/
package rip_pkg;
  // Register addresses on the CPU's byte register port
  localparam logic [7:0] ADDR_RADIO_IRQ_MASK = 8'h91;
  localparam logic [7:0] ADDR_RADIO_IRQ_FLAGS = 8'he9;
  localparam logic [7:0] ADDR_RADIO_DATA_PORT = 8'hd9;
  localparam logic [7:0] ADDR_CPU_IRQ_ENABLE_0 = 8'ha8;
  localparam logic [7:0] ADDR_CPU_IRQ_ENABLE_2 = 8'h9a;
  localparam logic [7:0] ADDR_TIMER_CONTROL_FLAGS = 8'h88;
  localparam logic [7:0] ADDR_CPU_FLAG_REGISTER = 8'h9b;
  // Flag bit positions in the flags and mask registers
  localparam int BIT_TX_UNDERFLOW = 7;
  localparam int BIT_RX_OVERFLOW = 6;
  localparam int BIT_RX_TIMEOUT = 5;
  localparam int BIT_PACKET_DONE = 4;
  localparam int BIT_CARRIER_SENSE = 3;
  localparam int BIT_PREAMBLE_QUALITY = 2;
  localparam int BIT_CLEAR_CHANNEL = 1;
  localparam int BIT_SYNC_DETECTED = 0;
  // Main enable and pending bit positions
  localparam int BIT_TRANSFER_IRQ_ENABLE = 0;
  localparam int BIT_COMBINED_IRQ_ENABLE = 0;
  localparam int BIT_TRANSFER_IRQ_PENDING = 1;
  localparam int BIT_COMBINED_IRQ_PENDING = 1;
  // Reset values
  localparam logic [7:0] RST_RADIO_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_RADIO_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // CPU interrupt vector numbers
  localparam logic [4:0] VEC_TRANSFER_IRQ = 5'h00;
  localparam logic [4:0] VEC_COMBINED_IRQ = 5'h0c;
  // Buffer depth of the data path
  localparam int DATA_BUF_DEPTH = 2;
endpackage

// file: src/rip_skid_buf.sv
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rip_skid_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = rip_pkg::DATA_BUF_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // The pointers and count are sized for exactly two entries
  if (DEPTH != 2) begin : g_bad_depth
    $error("rip_skid_buf supports DEPTH 2 only");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("rip_skid_buf needs WIDTH of at least 1");
  end

  logic [WIDTH-1:0] mem_ff [2];
  logic [WIDTH-1:0] nxt_mem [2];
  logic [1:0] cnt_ff, nxt_cnt;
  logic rd_ptr_ff, nxt_rd_ptr;
  logic wr_ptr_ff, nxt_wr_ptr;
  logic push, pop;

  // Honest full and empty from the count
  assign in_ready = (cnt_ff != 2'd2);
  assign out_valid = (cnt_ff != 2'd0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    nxt_mem = mem_ff;
    nxt_cnt = cnt_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_wr_ptr = wr_ptr_ff;
    if (push) begin
      nxt_mem[wr_ptr_ff] = in_data;
      nxt_wr_ptr = ~wr_ptr_ff;
    end
    if (pop) begin
      nxt_rd_ptr = ~rd_ptr_ff;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'd1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= 2'd0;
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      rd_ptr_ff <= nxt_rd_ptr;
      wr_ptr_ff <= nxt_wr_ptr;
      mem_ff <= nxt_mem;
    end
  end
endmodule
`default_nettype wire

// file: src/rip_top.sv
/*
  Radio interrupt combining and data port: flag/mask registers, main
  enables and pending bits, transfer request and the radio data register.
  Assumes a byte register port from the CPU core (one-cycle strobes) and
  radio event levels and byte handshakes on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rip_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // CPU register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Radio event levels, one per flag bit
  input wire logic [7:0] radio_event,
  // Transmit byte toward radio
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // Receive byte from radio
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  // Interrupt requests to CPU, and the dma_trigger transfer request pulse
  output logic transfer_irq,
  output logic [4:0] transfer_irq_vector,
  output logic combined_irq,
  output logic [4:0] combined_irq_vector,
  output logic dma_trigger
);
  logic [7:0] flags_ff, nxt_flags;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] event_prev_ff, nxt_event_prev;
  logic transfer_irq_enable_ff, nxt_transfer_irq_enable;
  logic combined_irq_enable_ff, nxt_combined_irq_enable;
  logic transfer_pend_ff, nxt_transfer_pend;
  logic combined_pend_ff, nxt_combined_pend;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [7:0] edge_set;
  logic [7:0] set_bits;
  logic tx_wr, rx_rd;
  logic txb_in_ready;
  logic rxb_out_valid;
  logic [7:0] rxb_out_data;
  logic rxb_fill_ready;
  logic req_raise;
  logic data_want_ff, nxt_data_want;
  // Byte movement on the data path
  logic data_moved;
  logic tx_pop, rx_push;
  // Write strobes, one per mapped register
  logic wr_flags, wr_mask, wr_enable_0, wr_enable_2, wr_timer_ctl, wr_cpu_flag;

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
    is_addr = (a == ref_a);
  endfunction

  // True when a field position lands inside the byte-wide registers
  function automatic logic pos_ok(input int pos);
    pos_ok = (pos >= 0) && (pos <= 7);
  endfunction

  // Refuse package edits that would move a field off its byte; the read mux
  // and the write masks index the byte directly and cannot serve them
  if (!pos_ok(rip_pkg::BIT_TX_UNDERFLOW) || !pos_ok(rip_pkg::BIT_RX_OVERFLOW)
      || !pos_ok(rip_pkg::BIT_RX_TIMEOUT) || !pos_ok(rip_pkg::BIT_PACKET_DONE)
      || !pos_ok(rip_pkg::BIT_CARRIER_SENSE) || !pos_ok(rip_pkg::BIT_PREAMBLE_QUALITY)
      || !pos_ok(rip_pkg::BIT_CLEAR_CHANNEL) || !pos_ok(rip_pkg::BIT_SYNC_DETECTED)
      || !pos_ok(rip_pkg::BIT_TRANSFER_IRQ_ENABLE)
      || !pos_ok(rip_pkg::BIT_COMBINED_IRQ_ENABLE)
      || !pos_ok(rip_pkg::BIT_TRANSFER_IRQ_PENDING)
      || !pos_ok(rip_pkg::BIT_COMBINED_IRQ_PENDING)) begin : g_bad_field
    $error("rip_top: a register field lies outside the byte");
  end

  // The data path relies on the two-entry buffer to ride out a stall
  if (rip_pkg::DATA_BUF_DEPTH != 2) begin : g_bad_depth
    $error("rip_top: the data buffer must hold exactly two bytes");
  end

  // Transmit buffer: a stall by the radio loses no byte already buffered; a write while both entries hold is dropped
  rip_skid_buf #(.WIDTH(8), .DEPTH(rip_pkg::DATA_BUF_DEPTH)) u_tx_buf (
    .clk(clk),
    .srst(srst),
    .in_valid(tx_wr),
    .in_ready(txb_in_ready),
    .in_data(reg_wdata),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  // Receive buffer: radio is stalled by rx_ready when both entries hold
  rip_skid_buf #(.WIDTH(8), .DEPTH(rip_pkg::DATA_BUF_DEPTH)) u_rx_buf (
    .clk(clk),
    .srst(srst),
    .in_valid(rx_valid),
    .in_ready(rxb_fill_ready),
    .in_data(rx_data),
    .out_valid(rxb_out_valid),
    .out_ready(rx_rd),
    .out_data(rxb_out_data)
  );

  assign rx_ready = rxb_fill_ready;

  // Data port strobes; a write into a full buffer is dropped
  assign tx_wr = reg_wr && is_addr(reg_addr, rip_pkg::ADDR_RADIO_DATA_PORT);
  assign rx_rd = reg_rd && is_addr(reg_addr, rip_pkg::ADDR_RADIO_DATA_PORT)
                 && rxb_out_valid;

  // Rising edges only, so a held level raises a flag once
  assign edge_set = radio_event & ~event_prev_ff;

  // Done also reports underflow and overflow
  always_comb begin
    set_bits = edge_set;
    set_bits[rip_pkg::BIT_PACKET_DONE] = edge_set[rip_pkg::BIT_PACKET_DONE]
        | edge_set[rip_pkg::BIT_TX_UNDERFLOW]
        | edge_set[rip_pkg::BIT_RX_OVERFLOW];
  end

  // Transfer request: receive byte waiting, or transmit room wanted.
  // Every byte moved through the data port, or taken by the radio, drops
  // the request for a cycle so it rises again: a host that waits for the
  // flag before each byte is never left waiting on a level that stays up.
  // Back-to-back moves merge into one request after the last of them.
  assign tx_pop = tx_valid && tx_ready;
  assign rx_push = rx_valid && rxb_fill_ready;
  assign data_moved = tx_wr || rx_rd || tx_pop || rx_push;
  assign nxt_data_want = (rxb_out_valid || txb_in_ready) && !data_moved;
  assign req_raise = nxt_data_want && !data_want_ff;
  assign dma_trigger = req_raise;

  // Write decode: one strobe per mapped register; other addresses hit nothing
  assign wr_flags = reg_wr && is_addr(reg_addr, rip_pkg::ADDR_RADIO_IRQ_FLAGS);
  assign wr_mask = reg_wr && is_addr(reg_addr, rip_pkg::ADDR_RADIO_IRQ_MASK);
  assign wr_enable_0 = reg_wr && is_addr(reg_addr, rip_pkg::ADDR_CPU_IRQ_ENABLE_0);
  assign wr_enable_2 = reg_wr && is_addr(reg_addr, rip_pkg::ADDR_CPU_IRQ_ENABLE_2);
  assign wr_timer_ctl = reg_wr && is_addr(reg_addr, rip_pkg::ADDR_TIMER_CONTROL_FLAGS);
  assign wr_cpu_flag = reg_wr && is_addr(reg_addr, rip_pkg::ADDR_CPU_FLAG_REGISTER);

  // Flag group: software may only clear, and a hardware set in the same
  // cycle as the clear wins, so an event arriving during the clear is kept
  always_comb begin
    nxt_event_prev = radio_event;
    nxt_flags = flags_ff;
    if (wr_flags) begin
      nxt_flags = flags_ff & reg_wdata;
    end
    // Flags keep updating even while masked
    nxt_flags = nxt_flags | set_bits;
  end

  // Control group: mask and main enables, changed only by software writes
  always_comb begin
    nxt_mask = mask_ff;
    nxt_transfer_irq_enable = transfer_irq_enable_ff;
    nxt_combined_irq_enable = combined_irq_enable_ff;
    if (wr_mask) begin
      nxt_mask = reg_wdata;
    end
    if (wr_enable_0) begin
      nxt_transfer_irq_enable = reg_wdata[rip_pkg::BIT_TRANSFER_IRQ_ENABLE];
    end
    if (wr_enable_2) begin
      nxt_combined_irq_enable = reg_wdata[rip_pkg::BIT_COMBINED_IRQ_ENABLE];
    end
  end

  // Pending group: writing 0 clears, writing 1 keeps; a set in the same
  // cycle wins. The combined bit re-asserts while any unmasked flag stays
  // set, so software must clear the source flags before this bit.
  always_comb begin
    nxt_transfer_pend = transfer_pend_ff;
    nxt_combined_pend = combined_pend_ff;
    if (wr_timer_ctl) begin
      nxt_transfer_pend = transfer_pend_ff
          & reg_wdata[rip_pkg::BIT_TRANSFER_IRQ_PENDING];
    end
    if (wr_cpu_flag) begin
      nxt_combined_pend = combined_pend_ff
          & reg_wdata[rip_pkg::BIT_COMBINED_IRQ_PENDING];
    end
    if (|(nxt_flags & mask_ff)) begin
      nxt_combined_pend = 1'b1;
    end
    if (req_raise) begin
      nxt_transfer_pend = 1'b1;
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      rip_pkg::ADDR_RADIO_IRQ_FLAGS: nxt_rdata = flags_ff;
      rip_pkg::ADDR_RADIO_IRQ_MASK: nxt_rdata = mask_ff;
      rip_pkg::ADDR_RADIO_DATA_PORT: nxt_rdata = rxb_out_valid ? rxb_out_data : 8'h00;
      rip_pkg::ADDR_CPU_IRQ_ENABLE_0:
        nxt_rdata[rip_pkg::BIT_TRANSFER_IRQ_ENABLE] = transfer_irq_enable_ff;
      rip_pkg::ADDR_CPU_IRQ_ENABLE_2:
        nxt_rdata[rip_pkg::BIT_COMBINED_IRQ_ENABLE] = combined_irq_enable_ff;
      rip_pkg::ADDR_TIMER_CONTROL_FLAGS:
        nxt_rdata[rip_pkg::BIT_TRANSFER_IRQ_PENDING] = transfer_pend_ff;
      rip_pkg::ADDR_CPU_FLAG_REGISTER:
        nxt_rdata[rip_pkg::BIT_COMBINED_IRQ_PENDING] = combined_pend_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Flag group registers; event history resets to the idle (low) level of
  // the radio conditions, so no false edge follows reset
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_ff <= rip_pkg::RST_RADIO_IRQ_FLAGS;
      event_prev_ff <= 8'h00;
    end else begin
      flags_ff <= nxt_flags;
      event_prev_ff <= nxt_event_prev;
    end
  end

  // Control group registers; main enables reset off so no interrupt
  // reaches the CPU before software has turned one on
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_ff <= rip_pkg::RST_RADIO_IRQ_MASK;
      transfer_irq_enable_ff <= rip_pkg::RST_CTRL[rip_pkg::BIT_TRANSFER_IRQ_ENABLE];
      combined_irq_enable_ff <= rip_pkg::RST_CTRL[rip_pkg::BIT_COMBINED_IRQ_ENABLE];
    end else begin
      mask_ff <= nxt_mask;
      transfer_irq_enable_ff <= nxt_transfer_irq_enable;
      combined_irq_enable_ff <= nxt_combined_irq_enable;
    end
  end

  // Pending group registers; both main pending bits start cleared and
  // are only raised by their own request logic
  always_ff @(posedge clk) begin
    if (srst) begin
      transfer_pend_ff <= rip_pkg::RST_CTRL[rip_pkg::BIT_TRANSFER_IRQ_PENDING];
      combined_pend_ff <= rip_pkg::RST_CTRL[rip_pkg::BIT_COMBINED_IRQ_PENDING];
    end else begin
      transfer_pend_ff <= nxt_transfer_pend;
      combined_pend_ff <= nxt_combined_pend;
    end
  end

  // Transfer request history: reset low, so the free transmit room raises
  // one request right after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      data_want_ff <= 1'b0;
    end else begin
      data_want_ff <= nxt_data_want;
    end
  end

  // Read data register: follows the address every cycle, so the value
  // stands one cycle after the address is presented
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs: pending gated by main enable, two-level for combined
  assign reg_rdata = rdata_ff;
  assign transfer_irq = transfer_pend_ff && transfer_irq_enable_ff;
  assign combined_irq = combined_pend_ff && combined_irq_enable_ff;
  assign transfer_irq_vector = rip_pkg::VEC_TRANSFER_IRQ;
  assign combined_irq_vector = rip_pkg::VEC_COMBINED_IRQ;
endmodule
`default_nettype wire

// file: test/rip_monitor.sv
/* Port checker for rip_top.
   Bound to every rip_top instance; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module rip_monitor (
  // Clock, reset, register port
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Data and interrupt outputs
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic transfer_irq,
  input wire logic [4:0] transfer_irq_vector,
  input wire logic combined_irq,
  input wire logic [4:0] combined_irq_vector,
  input wire logic dma_trigger
);
  logic [7:0] mask_ff;
  logic ten_ff;
  logic cen_ff;
  // Shadow copies of the mask and main enables, rebuilt from the writes
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_ff <= 8'h00;
      ten_ff <= 1'b0;
      cen_ff <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == rip_pkg::ADDR_RADIO_IRQ_MASK) mask_ff <= reg_wdata;
      if (reg_addr == rip_pkg::ADDR_CPU_IRQ_ENABLE_0) ten_ff <= reg_wdata[0];
      if (reg_addr == rip_pkg::ADDR_CPU_IRQ_ENABLE_2) cen_ff <= reg_wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_vec_transfer: assert property (transfer_irq_vector == 5'h00)
    else $error("transfer vector wrong");
  a_vec_combined: assert property (combined_irq_vector == 5'h0c)
    else $error("combined vector wrong");
  a_tx_word_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("stalled byte lost");
  a_dma_one_pulse: assert property (dma_trigger |=> !dma_trigger)
    else $error("request not a pulse");
  a_combined_gated: assert property (combined_irq |-> cen_ff)
    else $error("combined irq while disabled");
  a_transfer_gated: assert property (transfer_irq |-> ten_ff)
    else $error("transfer irq while disabled");
  a_mask_readback: assert property ((reg_addr == 8'h91) && !reg_wr |=> reg_rdata == mask_ff)
    else $error("mask readback wrong");
  a_enable_readback: assert property ((reg_addr == 8'h9a) && !reg_wr |=> reg_rdata[0] == cen_ff)
    else $error("enable readback wrong");
  c_combined: cover property (combined_irq);
  c_transfer: cover property (transfer_irq);
  c_tx_stall: cover property (tx_valid && !tx_ready);
endmodule
bind rip_top rip_monitor mon (.*);
`default_nettype wire

// file: test/rip_radio_model.sv
/* Radio-side model: takes transmit bytes, offers receive bytes.
   Assumes the bench drives stall, send and send_byte at the clock edge. */
`timescale 1ns/1ps
`default_nettype none
module rip_radio_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bench controls
  input wire logic stall,
  input wire logic send,
  input wire logic [7:0] send_byte,
  // Transmit side
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  // Receive side
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data
);
  logic [7:0] got[$];
  // A stalled radio refuses bytes so the buffer must hold them
  assign tx_ready = !stall;
  initial rx_data = 8'h55;
  // Offer held until taken; then the data lines no longer show the byte
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    if (srst) begin
      rx_valid <= 1'b0;
    end else if (send) begin
      rx_valid <= 1'b1;
      rx_data <= send_byte;
    end else if (rx_valid && rx_ready) begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end
  end
endmodule
`default_nettype wire

// file: test/rip_top_bench.sv
/* Self-checking bench for rip_top.
   Assumes the package, monitor and radio model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module rip_top_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] radio_event = 8'h00;
  logic stall = 1'b0;
  logic send = 1'b0;
  logic [7:0] send_byte = 8'h00;
  logic [7:0] reg_rdata, tx_data, rx_data;
  logic tx_valid, tx_ready, rx_valid, rx_ready, transfer_irq, combined_irq, dma_trigger;
  logic [4:0] tvec, cvec;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int dma_pulses = 0;
  always #25 clk = ~clk;
  rip_top uut (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .radio_event(radio_event), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .transfer_irq(transfer_irq), .transfer_irq_vector(tvec), .combined_irq(combined_irq),
    .combined_irq_vector(cvec), .dma_trigger(dma_trigger));
  rip_radio_model radio (.clk(clk), .srst(srst), .stall(stall), .send(send),
    .send_byte(send_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data lands one edge after the strobe, so look just past it
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
  endtask
  task automatic snd(input logic [7:0] b);
    @(posedge clk);
    send <= 1'b1;
    send_byte <= b;
    @(posedge clk);
    send <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Each source held high: one set, no re-set from the level after clearing
  task automatic t_flags();
    logic [7:0] e;
    for (int b = 0; b < 8; b++) begin
      e = (8'h01 << b) | ((b > 5) ? 8'h10 : 8'h00);
      @(posedge clk) radio_event <= 8'h01 << b;
      wr(8'he9, 8'hff);
      rdc(8'he9, e);
      wr(8'he9, 8'h00);
      rdc(8'he9, 8'h00);
      @(posedge clk) radio_event <= 8'h00;
    end
    check({7'b0, combined_irq}, 8'h00);
    $display("flags test done");
  endtask
  task automatic t_irq();
    wr(8'h9a, 8'h01);
    wr(8'h91, 8'h01);
    rdc(8'h91, 8'h01);
    @(posedge clk) radio_event <= 8'h01;
    repeat (4) @(posedge clk);
    #1 check({7'b0, combined_irq}, 8'h01);
    wr(8'he9, 8'h00);
    wr(8'h9b, 8'h00);
    #1 check({7'b0, combined_irq}, 8'h00);
    wr(8'h9a, 8'h00);
    @(posedge clk) radio_event <= 8'h00;
    @(posedge clk) radio_event <= 8'h01;
    repeat (4) @(posedge clk);
    #1 check({7'b0, combined_irq}, 8'h00);
    rdc(8'h9b, 8'h02);
    check({3'b0, cvec}, 8'h0c);
    check({3'b0, tvec}, 8'h00);
    @(posedge clk) radio_event <= 8'h00;
    $display("irq test done");
  endtask
  // Stalled radio: two bytes buffered, the third refused
  task automatic t_tx();
    int n0;
    check({7'b0, transfer_irq}, 8'h00);
    wr(8'ha8, 8'h01);
    #1 check({7'b0, transfer_irq}, 8'h01);
    wr(8'h88, 8'h00);
    n0 = dma_pulses;
    stall <= 1'b1;
    wr(8'hd9, 8'h02);
    rdc(8'h88, 8'h02);
    check(8'(dma_pulses - n0), 8'h01);
    wr(8'h88, 8'h00);
    wr(8'hd9, 8'h12);
    wr(8'hd9, 8'h34);
    #1 check({7'b0, tx_valid}, 8'h01);
    @(posedge clk) stall <= 1'b0;
    repeat (4) @(posedge clk);
    check(8'(radio.got.size()), 8'h02);
    check(radio.got[0], 8'h02);
    check(radio.got[1], 8'h12);
    rdc(8'h88, 8'h02);
    $display("tx test done");
  endtask
  task automatic t_rx();
    snd(8'ha5);
    snd(8'h5a);
    snd(8'hc3);
    #1 check({7'b0, rx_ready}, 8'h00);
    rdc(8'hd9, 8'ha5);
    rdc(8'hd9, 8'h5a);
    rdc(8'hd9, 8'hc3);
    rdc(8'hd9, 8'h00);
    $display("rx test done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (dma_trigger === 1'b1) begin
      dma_pulses++;
    end
    if (cycles == 4000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_flags();
    t_irq();
    t_tx();
    t_rx();
    finish_test();
  end
endmodule
`default_nettype wire
